// ---- shared/csc_pkg.sv ----
// package: constants, carrier structs and state record of the config and sleep control block
// Functional notes
// R1: low request pin enters sleep, high leaves
// R2: sleep stops logic, loses contents, tristates I/Os
// R3: test port and programming dead while asleep
// R4: controller must not sleep during programming; the code's sleep entry does not check the current instruction
// R5: sleep request pin glitch filtered, defaults awake
// R6: dedicated bit enables the internal oscillator
// R7: serial test port shifts, drives, captures nodes
// R8: offline programming drives pins from scan cells; the code drives pins from the scan cells under EXTEST only
// R9: background programming keeps user design running
// R10: power-up loads configuration from non-volatile memory
// R11: refresh command reloads configuration from non-volatile
// R12: configuration directly loadable over test port
// R13: pins high, low, floating or held meanwhile
// R14: security bits block readback of both memories
// R15: only an erase clears the security bits; reset clears them too
// R16: wake-up reloads configuration, restarts user logic
package csc_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int CSC_NIO = 4;
  localparam int CSC_WORDS = 8;
  localparam int CSC_CLK_NS = 5;
  localparam int CSC_SLEEP_FILT_NS = 200;
  localparam int CSC_SLEEP_FILT_CYC = (CSC_SLEEP_FILT_NS + CSC_CLK_NS - 1) / CSC_CLK_NS;
  localparam logic [5:0] CSC_FILT_LAST = 6'(CSC_SLEEP_FILT_CYC - 1);
  localparam logic [2:0] CSC_LD_LAST = 3'(CSC_WORDS - 1);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CSC_OFS_IO_MODE = 8'h04;
  localparam logic [7:0] CSC_OFS_STATUS = 8'h08;
  localparam int CSC_CTRL_OSC_EN_BIT = 0;
  localparam int CSC_ST_RUN_BIT = 0;
  localparam int CSC_ST_SLEEP_BIT = 1;
  localparam int CSC_ST_LOAD_BIT = 2;
  localparam int CSC_ST_OFFLINE_BIT = 3;
  localparam int CSC_ST_SEC_BIT = 4;
  localparam int CSC_ST_BG_BIT = 5;
  localparam int CSC_ST_IR_POS = 8;
  localparam logic CSC_OSC_EN_RST = 1'b1;
  localparam logic [7:0] CSC_IO_MODE_RST = 8'hff;
  localparam logic [1:0] CSC_RESP_OKAY = 2'b00;
  localparam logic [1:0] CSC_RESP_SLVERR = 2'b10;

  // per-pin behaviour while the device is offline
  localparam logic [1:0] CSC_IOM_HIGH = 2'b00;
  localparam logic [1:0] CSC_IOM_LOW = 2'b01;
  localparam logic [1:0] CSC_IOM_FLOAT = 2'b10;
  localparam logic [1:0] CSC_IOM_HOLD = 2'b11;

  // ----------------------------------------------------------------
  // test port instructions
  // ----------------------------------------------------------------
  localparam logic [3:0] CSC_I_EXTEST = 4'h0;
  localparam logic [3:0] CSC_I_SAMPLE = 4'h1;
  localparam logic [3:0] CSC_I_PROG_NVM = 4'h2;
  localparam logic [3:0] CSC_I_PROG_BG = 4'h3;
  localparam logic [3:0] CSC_I_LOAD_CFG = 4'h4;
  localparam logic [3:0] CSC_I_REFRESH = 4'h5;
  localparam logic [3:0] CSC_I_READ_NVM = 4'h6;
  localparam logic [3:0] CSC_I_READ_CFG = 4'h7;
  localparam logic [3:0] CSC_I_SET_SEC = 4'h8;
  localparam logic [3:0] CSC_I_ERASE = 4'h9;
  localparam logic [3:0] CSC_I_BYPASS = 4'hf;
  localparam logic [3:0] CSC_IR_CAPTURE = 4'h1;
  localparam logic [63:0] CSC_NVM_RST = 64'h0;
  localparam logic [63:0] CSC_NVM_ERASED = 64'hffff_ffff_ffff_ffff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSC_LOAD = 3'b001,
    CSC_RUN = 3'b010,
    CSC_SLEEP = 3'b100
  } csc_mode_t;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } csc_tap_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } csc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csc_axi_rsp_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } csc_tap_pins_t;

  typedef struct packed {
    csc_mode_t mode;
    logic [2:0] ld_idx;
    logic [5:0] filt_cnt;
    csc_tap_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [10:0] dr_sh;
    logic [3:0] bsr;
    logic [2:0] addr;
    logic [7:0][7:0] nvm;
    logic [7:0][7:0] sram;
    logic sec;
    logic tck_q;
    logic tdo;
    logic tdo_oe_n;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic user_run;
    logic osc_en;
    logic [7:0] io_mode;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wbyte;
    csc_axi_rsp_t rsp;
  } csc_state_t;

endpackage

// ---- verilog/csc_ctrl.sv ----
// config and sleep control: sleep entry, oscillator enable, test port configuration engine
`timescale 1ns/1ps

module csc_ctrl
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire csc_axi_req_t axi_req,
  output csc_axi_rsp_t axi_rsp,
  input wire logic low_power_request_n,
  input wire csc_tap_pins_t tap_pins,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [3:0] user_dout,
  input wire logic [3:0] user_doe,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  output logic user_run,
  output logic osc_en,
  output logic asleep,
  output logic [63:0] cfg_image
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  csc_state_t state_r;
  csc_state_t state_nxt;

  function automatic csc_tap_t tap_next(input csc_tap_t s, input logic tms);
    case (s)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      default: tap_next = TAP_TLR;
    endcase
  endfunction

  // top bit of the selected data chain; tdi enters there
  function automatic logic [3:0] dr_msb(input logic [3:0] ir);
    case (ir)
      CSC_I_EXTEST, CSC_I_SAMPLE: dr_msb = 4'h3;
      CSC_I_PROG_NVM, CSC_I_PROG_BG, CSC_I_LOAD_CFG, CSC_I_READ_NVM, CSC_I_READ_CFG: dr_msb = 4'ha;
      default: dr_msb = 4'h0;
    endcase
  endfunction

  function automatic logic is_offline_ir(input logic [3:0] ir);
    is_offline_ir = (ir == CSC_I_EXTEST) || (ir == CSC_I_PROG_NVM) || (ir == CSC_I_LOAD_CFG) ||
                    (ir == CSC_I_ERASE);
  endfunction

  function automatic logic [31:0] reg_read(input csc_state_t s, input logic [7:0] a);
    reg_read = 32'h0;
    case (a)
      CSC_OFS_CTRL: reg_read[CSC_CTRL_OSC_EN_BIT] = s.osc_en;
      CSC_OFS_IO_MODE: reg_read[7:0] = s.io_mode;
      CSC_OFS_STATUS:
      begin
        reg_read[CSC_ST_RUN_BIT] = s.user_run;
        reg_read[CSC_ST_SLEEP_BIT] = (s.mode == CSC_SLEEP);
        reg_read[CSC_ST_LOAD_BIT] = (s.mode == CSC_LOAD);
        reg_read[CSC_ST_OFFLINE_BIT] = (s.mode == CSC_LOAD) || is_offline_ir(s.ir);
        reg_read[CSC_ST_SEC_BIT] = s.sec;
        reg_read[CSC_ST_BG_BIT] = (s.ir == CSC_I_PROG_BG);
        reg_read[CSC_ST_IR_POS +: 4] = s.ir;
      end
      default: reg_read = 32'h0;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == CSC_OFS_CTRL) || (a == CSC_OFS_IO_MODE) || (a == CSC_OFS_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic tck_rise;
    logic tck_fall;
    logic offline;
    tck_rise = 1'b0;
    tck_fall = 1'b0;
    offline = 1'b0;
    state_nxt = state_r;
    state_nxt.tck_q = tap_pins.tck;

    // -- sleep request filter: short lows never reach the mode machine
    if (low_power_request_n)
    begin
      state_nxt.filt_cnt = 6'h00;
    end
    else if (state_r.filt_cnt != CSC_FILT_LAST)
    begin
      state_nxt.filt_cnt = state_r.filt_cnt + 6'h01; // R5
    end

    // -- mode machine
    case (state_r.mode)
      CSC_LOAD:
      begin
        state_nxt.sram[state_r.ld_idx] = state_r.nvm[state_r.ld_idx]; // R10 R11 R16
        state_nxt.ld_idx = state_r.ld_idx + 3'h1;
        if (state_r.ld_idx == CSC_LD_LAST)
        begin
          state_nxt.mode = CSC_RUN;
        end
      end
      CSC_RUN: state_nxt.mode = CSC_RUN;
      CSC_SLEEP:
      begin
        if (low_power_request_n)
        begin
          state_nxt.mode = CSC_LOAD; // R1 R16
          state_nxt.ld_idx = 3'h0;
        end
      end
      default: state_nxt.mode = CSC_LOAD;
    endcase

    // -- test port, live only outside sleep
    if (state_r.mode != CSC_SLEEP)
    begin
      tck_rise = tap_pins.tck && !state_r.tck_q;
      tck_fall = !tap_pins.tck && state_r.tck_q;
    end
    if (tck_fall)
    begin
      // tdo moves on the falling edge so the controller samples it stable on the next rise
      state_nxt.tdo = (state_r.tap == TAP_SH_IR) ? state_r.ir_sh[0] : state_r.dr_sh[0]; // R7
      state_nxt.tdo_oe_n = !((state_r.tap == TAP_SH_IR) || (state_r.tap == TAP_SH_DR));
    end
    if (tck_rise)
    begin
      state_nxt.tap = tap_next(state_r.tap, tap_pins.tms); // R7
      case (state_r.tap)
        TAP_TLR: state_nxt.ir = CSC_I_BYPASS;
        TAP_CAP_IR: state_nxt.ir_sh = CSC_IR_CAPTURE;
        TAP_SH_IR: state_nxt.ir_sh = {tap_pins.tdi, state_r.ir_sh[3:1]};
        TAP_UPD_IR:
        begin
          state_nxt.ir = state_r.ir_sh;
          case (state_r.ir_sh)
            CSC_I_REFRESH:
            begin
              state_nxt.mode = CSC_LOAD; // R11
              state_nxt.ld_idx = 3'h0;
            end
            CSC_I_SET_SEC: state_nxt.sec = 1'b1; // R14
            CSC_I_ERASE:
            begin
              state_nxt.nvm = CSC_NVM_ERASED; // R15
              state_nxt.sec = 1'b0; // R15
            end
            default: state_nxt.sec = state_r.sec;
          endcase
        end
        TAP_CAP_DR:
        begin
          case (state_r.ir)
            CSC_I_EXTEST, CSC_I_SAMPLE: state_nxt.dr_sh = {7'h00, io_in}; // R7
            CSC_I_READ_NVM: state_nxt.dr_sh = {state_r.addr, state_r.sec ? 8'h00 : state_r.nvm[state_r.addr]}; // R14
            CSC_I_READ_CFG: state_nxt.dr_sh = {state_r.addr, state_r.sec ? 8'h00 : state_r.sram[state_r.addr]}; // R14
            default: state_nxt.dr_sh = {state_r.addr, 8'h00};
          endcase
        end
        TAP_SH_DR:
        begin
          state_nxt.dr_sh = {1'b0, state_r.dr_sh[10:1]};
          state_nxt.dr_sh[dr_msb(state_r.ir)] = tap_pins.tdi; // R7
        end
        TAP_UPD_DR:
        begin
          case (state_r.ir)
            CSC_I_EXTEST, CSC_I_SAMPLE: state_nxt.bsr = state_r.dr_sh[3:0]; // R7
            CSC_I_PROG_NVM, CSC_I_PROG_BG:
            begin
              state_nxt.nvm[state_r.dr_sh[10:8]] = state_r.dr_sh[7:0]; // R8 R9
              state_nxt.addr = state_r.dr_sh[10:8];
            end
            CSC_I_LOAD_CFG:
            begin
              state_nxt.sram[state_r.dr_sh[10:8]] = state_r.dr_sh[7:0]; // R12
              state_nxt.addr = state_r.dr_sh[10:8];
            end
            CSC_I_READ_NVM, CSC_I_READ_CFG: state_nxt.addr = state_r.dr_sh[10:8];
            default: state_nxt.addr = state_r.addr;
          endcase
        end
        default: state_nxt.ir = state_r.ir;
      endcase
    end

    // -- sleep entry overrides any mode change the test port made this cycle
    if (state_r.mode != CSC_SLEEP && !low_power_request_n && state_r.filt_cnt == CSC_FILT_LAST)
    begin
      state_nxt.mode = CSC_SLEEP; // R1
    end
    if (state_r.mode == CSC_SLEEP)
    begin
      state_nxt.sram = '0; // R2
      state_nxt.bsr = 4'h0;
      state_nxt.tap = TAP_TLR; // R3
      state_nxt.ir = CSC_I_BYPASS; // R3
      state_nxt.tdo = 1'b0;
      state_nxt.tdo_oe_n = 1'b1;
    end

    // -- pins and user logic
    offline = (state_r.mode == CSC_LOAD) || is_offline_ir(state_r.ir);
    state_nxt.user_run = (state_r.mode == CSC_RUN) && !offline; // R2 R9 R16
    for (int i = 0; i < CSC_NIO; i++)
    begin
      if (state_r.mode == CSC_SLEEP)
      begin
        state_nxt.io_oe_n[i] = 1'b1; // R2
      end
      else if (state_r.ir == CSC_I_EXTEST)
      begin
        state_nxt.io_out[i] = state_r.bsr[i]; // R8
        state_nxt.io_oe_n[i] = 1'b0;
      end
      else if (offline)
      begin
        case (state_r.io_mode[2*i +: 2])
          CSC_IOM_HIGH:
          begin
            state_nxt.io_out[i] = 1'b1; // R13
            state_nxt.io_oe_n[i] = 1'b0;
          end
          CSC_IOM_LOW:
          begin
            state_nxt.io_out[i] = 1'b0; // R13
            state_nxt.io_oe_n[i] = 1'b0;
          end
          CSC_IOM_FLOAT: state_nxt.io_oe_n[i] = 1'b1; // R13
          default: state_nxt.io_out[i] = state_r.io_out[i]; // R13
        endcase
      end
      else
      begin
        state_nxt.io_out[i] = user_dout[i]; // R9
        state_nxt.io_oe_n[i] = !user_doe[i];
      end
    end

    // -- register bus: address and data accepted in either order
    state_nxt.rsp.awready = axi_req.awvalid && !state_r.rsp.awready && !state_r.aw_have && !state_r.rsp.bvalid;
    state_nxt.rsp.wready = axi_req.wvalid && !state_r.rsp.wready && !state_r.w_have && !state_r.rsp.bvalid;
    if (axi_req.awvalid && state_r.rsp.awready)
    begin
      state_nxt.aw_have = 1'b1;
      state_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_r.rsp.wready)
    begin
      state_nxt.w_have = 1'b1;
      state_nxt.wdata = axi_req.wdata[7:0];
      state_nxt.wbyte = axi_req.wstrb[0];
    end
    if (state_r.aw_have && state_r.w_have)
    begin
      state_nxt.aw_have = 1'b0;
      state_nxt.w_have = 1'b0;
      state_nxt.rsp.bvalid = 1'b1;
      state_nxt.rsp.bresp = reg_mapped(state_r.awaddr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
      if (state_r.wbyte && state_r.awaddr == CSC_OFS_CTRL)
      begin
        state_nxt.osc_en = state_r.wdata[CSC_CTRL_OSC_EN_BIT]; // R6
      end
      if (state_r.wbyte && state_r.awaddr == CSC_OFS_IO_MODE)
      begin
        state_nxt.io_mode = state_r.wdata; // R13
      end
    end
    else if (state_r.rsp.bvalid && axi_req.bready)
    begin
      state_nxt.rsp.bvalid = 1'b0;
    end
    state_nxt.rsp.arready = axi_req.arvalid && !state_r.rsp.arready && !state_r.rsp.rvalid;
    if (axi_req.arvalid && state_r.rsp.arready)
    begin
      state_nxt.rsp.rvalid = 1'b1;
      state_nxt.rsp.rdata = reg_read(state_r, axi_req.araddr);
      state_nxt.rsp.rresp = reg_mapped(axi_req.araddr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
    end
    else if (state_r.rsp.rvalid && axi_req.rready)
    begin
      state_nxt.rsp.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      // reset stands for power-up: start by loading the image
      state_r <= '0;
      state_r.mode <= CSC_LOAD; // R10
      state_r.tap <= TAP_TLR;
      state_r.ir <= CSC_I_BYPASS;
      state_r.nvm <= CSC_NVM_RST;
      state_r.tdo_oe_n <= 1'b1;
      state_r.io_oe_n <= 4'hf;
      state_r.osc_en <= CSC_OSC_EN_RST;
      state_r.io_mode <= CSC_IO_MODE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from the state record
  // ----------------------------------------------------------------
  assign axi_rsp = state_r.rsp;
  assign tdo = state_r.tdo;
  assign tdo_oe_n = state_r.tdo_oe_n;
  assign io_out = state_r.io_out;
  assign io_oe_n = state_r.io_oe_n;
  assign user_run = state_r.user_run;
  assign osc_en = state_r.osc_en;
  assign asleep = (state_r.mode == CSC_SLEEP);
  assign cfg_image = state_r.sram;

endmodule

// ---- testbench/csc_ctrl_assertions.sv ----
// checker for the config and sleep control block, bound to its ports
`timescale 1ns/1ps

module csc_ctrl_assertions
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire csc_axi_req_t axi_req,
  input wire csc_axi_rsp_t axi_rsp,
  input wire logic low_power_request_n,
  input wire csc_tap_pins_t tap_pins,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [3:0] user_dout,
  input wire logic [3:0] user_doe,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  input wire logic user_run,
  input wire logic osc_en,
  input wire logic asleep,
  input wire logic [63:0] cfg_image
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);

  // run length of the low request, saturating so a long sleep cannot wrap it
  logic [5:0] low_cnt;
  always_ff @(posedge clock)
  begin
    if (srst || low_power_request_n)
      low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f)
      low_cnt <= low_cnt + 6'h01;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_sleep_pins;
    asleep && $past(asleep) |-> io_oe_n == 4'hf;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("pins driven in sleep");
  property p_sleep_wipe;
    asleep && $past(asleep) |-> cfg_image == 64'h0 && !user_run;
  endproperty
  a_sleep_wipe: assert property (p_sleep_wipe) else $error("state kept in sleep");
  property p_sleep_tap;
    asleep && $past(asleep) |-> tdo_oe_n;
  endproperty
  a_sleep_tap: assert property (p_sleep_tap) else $error("test port active in sleep");
  property p_filter;
    $rose(asleep) |-> $past(low_cnt) >= CSC_FILT_LAST;
  endproperty
  a_filter: assert property (p_filter) else $error("sleep entered on short low");
  property p_enter;
    low_cnt == 6'h32 |-> asleep;
  endproperty
  a_enter: assert property (p_enter) else $error("long low did not sleep");
  property p_wake;
    asleep && low_power_request_n |-> ##2 !asleep;
  endproperty
  a_wake: assert property (p_wake) else $error("high request did not wake");
  property p_reload;
    $fell(asleep) |-> !user_run [*6] ##[1:20] user_run;
  endproperty
  a_reload: assert property (p_reload) else $error("wake without reload");
  property p_boot;
    $fell(srst) |-> !user_run [*6] ##[1:12] user_run;
  endproperty
  a_boot: assert property (p_boot) else $error("start without load");

  c_sleep: cover property ($rose(asleep));
  c_wake: cover property ($fell(asleep));
  c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == CSC_RESP_SLVERR);
endmodule

bind csc_ctrl csc_ctrl_assertions csc_ctrl_assertions_inst (.clock(clock), .srst(srst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .low_power_request_n(low_power_request_n), .tap_pins(tap_pins), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .user_dout(user_dout), .user_doe(user_doe), .io_in(io_in), .io_out(io_out),
  .io_oe_n(io_oe_n), .user_run(user_run), .osc_en(osc_en), .asleep(asleep), .cfg_image(cfg_image));

// ---- testbench/csc_tap_host.sv ----
// test port host model: drives serial frames and collects returned bits
`timescale 1ns/1ps

module csc_tap_host
  import csc_pkg::*;
(
  input wire logic clock,
  output csc_tap_pins_t tap_pins,
  input wire logic tdo
);
  // test clock stands low between frames
  initial
    tap_pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

  // each phase lasts 3 system clocks, above the 2 the sampler needs; tdo taken just before the rise
  task automatic step(input logic ms, input logic di, output logic q);
    tap_pins.tms <= ms;
    tap_pins.tdi <= di;
    repeat (3) @(posedge clock);
    q = tdo;
    tap_pins.tck <= 1'b1;
    repeat (3) @(posedge clock);
    tap_pins.tck <= 1'b0;
  endtask

  task automatic reset;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // idle, shift lsb first, update, back to idle
  task automatic shift(input logic is_ir, input int n, input logic [10:0] din, output logic [10:0] dout);
    logic q;
    dout = 11'h000;
    step(1'b1, 1'b0, q);
    if (is_ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tap_pins.tdi <= ~din[n - 1];
  endtask
endmodule

// ---- testbench/test_csc_ctrl.sv ----
// self-checking bench: register bus, test port programming and sleep
`timescale 1ns/1ps

module test_csc_ctrl import csc_pkg::*;;
  logic clock, srst, lp_n, tdo, tdo_oe_n, run, osc, asleep;
  csc_axi_req_t req;
  csc_axi_rsp_t rsp;
  csc_tap_pins_t tap;
  logic [3:0] dout, doe, pin_in, pin_out, pin_oe_n;
  logic [63:0] cfg, img;
  logic [10:0] o;
  int num_errors, num_checks;

  csc_ctrl csc_ctrl_inst (.clock(clock), .srst(srst), .axi_req(req), .axi_rsp(rsp), .low_power_request_n(lp_n),
    .tap_pins(tap), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .user_dout(dout), .user_doe(doe), .io_in(pin_in),
    .io_out(pin_out), .io_oe_n(pin_oe_n), .user_run(run), .osc_en(osc), .asleep(asleep), .cfg_image(cfg));
  csc_tap_host csc_tap_host_inst (.clock(clock), .tap_pins(tap), .tdo(tdo));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every polling wait goes through here so a hang ends the run
  task automatic guard(inout int n);
    @(posedge clock);
    n++;
    if (n > 300)
    begin
      chk("wait", 64'h1, 64'h0);
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w))
    begin
      guard(n);
      if (rsp.awready === 1'b1)
      begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready === 1'b1)
      begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1)
      guard(n);
    req.bready <= 1'b0;
    chk("bresp", 64'(er), 64'(rsp.bresp));
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (rsp.arready !== 1'b1)
      guard(n);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1)
      guard(n);
    req.rready <= 1'b0;
    chk("rdata", 64'(exp), 64'(rsp.rdata & m));
    chk("rresp", 64'(er), 64'(rsp.rresp));
  endtask

  task automatic ir(input logic [3:0] c);
    csc_tap_host_inst.shift(1'b1, 4, {7'h00, c}, o);
  endtask

  task automatic dr(input int n, input logic [10:0] d);
    csc_tap_host_inst.shift(1'b0, n, d, o);
  endtask

  // first frame sets the address, second returns it with its data
  task automatic rb(input logic [3:0] c, input logic [2:0] a, input logic [10:0] exp);
    ir(c);
    dr(11, {a, 8'h00});
    dr(11, {a, 8'h00});
    chk("readback", 64'(exp), 64'(o));
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (run !== 1'b1)
      guard(n);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    lp_n = 1'b1;
    req = '0;
    req.wstrb = 4'hf;
    dout = 4'h6;
    doe = 4'h3;
    pin_in = 4'h5;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    wait_run();
    chk("cfg", CSC_NVM_RST, cfg);
    rd(CSC_OFS_CTRL, 32'h1, 32'h1, CSC_RESP_OKAY);
    rd(CSC_OFS_IO_MODE, 32'hff, 32'hff, CSC_RESP_OKAY);
    rd(8'h0c, 32'hffff_ffff, 32'h0, CSC_RESP_SLVERR);
    wr(8'h10, 32'h0, CSC_RESP_SLVERR);
    wr(CSC_OFS_CTRL, 32'h0, CSC_RESP_OKAY);
    chk("osc", 64'h0, 64'(osc));
    wr(CSC_OFS_CTRL, 32'h1, CSC_RESP_OKAY);
    chk("osc", 64'h1, 64'(osc));
    csc_tap_host_inst.reset();
    ir(CSC_I_SAMPLE);
    dr(4, 11'h00a);
    chk("capture", 64'h5, 64'(o[3:0]));
    ir(CSC_I_EXTEST);
    chk("scan_out", 64'ha, 64'(pin_out));
    chk("scan_oe", 64'h0, 64'(pin_oe_n));
    wr(CSC_OFS_IO_MODE, {24'h0, CSC_IOM_HOLD, CSC_IOM_FLOAT, CSC_IOM_LOW, CSC_IOM_HIGH}, CSC_RESP_OKAY);
    ir(CSC_I_PROG_NVM);
    chk("mode_oe", 64'h4, 64'(pin_oe_n));
    chk("mode_out", 64'h9, 64'(pin_out & 4'hb));
    rd(CSC_OFS_STATUS, 32'h8, 32'h8, CSC_RESP_OKAY);
    for (int k = 0; k < 8; k++)
    begin
      img[8*k +: 8] = 8'(k * 19 + 5);
      dr(11, {3'(k), img[8*k +: 8]});
    end
    chk("cfg", 64'h0, cfg);
    ir(CSC_I_REFRESH);
    repeat (12) @(posedge clock);
    chk("refresh", img, cfg);
    ir(CSC_I_LOAD_CFG);
    dr(11, {3'd2, 8'h5a});
    chk("load", 64'h5a, 64'(cfg[23:16]));
    rb(CSC_I_READ_CFG, 3'd2, 11'h25a);
    ir(CSC_I_SET_SEC);
    rb(CSC_I_READ_CFG, 3'd2, 11'h200);
    rb(CSC_I_READ_NVM, 3'd1, 11'h100);
    ir(CSC_I_REFRESH);
    rd(CSC_OFS_STATUS, 32'h10, 32'h10, CSC_RESP_OKAY);
    ir(CSC_I_ERASE);
    rd(CSC_OFS_STATUS, 32'h10, 32'h0, CSC_RESP_OKAY);
    rb(CSC_I_READ_NVM, 3'd1, 11'h1ff);
    ir(CSC_I_PROG_BG);
    dr(11, {3'd6, 8'h77});
    chk("bg_run", 64'h1, 64'(run));
    chk("bg_oe", 64'hc, 64'(pin_oe_n));
    rd(CSC_OFS_STATUS, 32'h21, 32'h21, CSC_RESP_OKAY);
    ir(CSC_I_BYPASS);
    lp_n <= 1'b0;
    repeat (30) @(posedge clock);
    lp_n <= 1'b1;
    repeat (5) @(posedge clock);
    chk("glitch", 64'h0, 64'(asleep));
    lp_n <= 1'b0;
    repeat (50) @(posedge clock);
    chk("asleep", 64'h1, 64'(asleep));
    chk("sleep_oe", 64'hf, 64'(pin_oe_n));
    chk("sleep_cfg", 64'h0, cfg);
    ir(CSC_I_READ_CFG);
    lp_n <= 1'b1;
    wait_run();
    chk("wake_cfg", 64'hff77_ffff_ffff_ffff, cfg);
    rd(CSC_OFS_STATUS, 32'hf02, 32'hf00, CSC_RESP_OKAY);
    test_done();
  end
endmodule
